// File: sim/hmc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module hmc_monitor (
    // clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // timing loop
    input wire logic        ref_lost,
    input wire logic        ref_dead,
    input wire logic [1:0]  loop_state,
    input wire logic [18:0] hold_freq,
    input wire logic        hold_active
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////
    // register port checks and reset values of the loop outputs
    a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    // a control write followed by its readback returns the stored upper field
    property p_ctrl_readback;
        logic [7:0] d;
        (reg_wr && reg_addr == 8'h40, d = reg_wdata) ##1 (reg_rd && reg_addr == 8'h40)
        |=> reg_rdata[7:3] == d[7:3];
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback)
        else $error("control readback differs from write");
    a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {8'h3e, 8'h3f, 8'h40})
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reset_state: assert property ($past(srst) |-> loop_state == 2'b11 && !hold_active
        && hold_freq == 19'h0)
        else $error("outputs not at reset values");
    ////////////////////////////////////////////////////////////////
    // loop state checks
    a_lost_mini: assert property (loop_state == 2'b00 && ref_lost |-> ##[1:2] loop_state == 2'b01)
        else $error("no mini-holdover after reference loss");
    a_dead_full: assert property (loop_state == 2'b01 && ref_dead |-> ##[1:2] loop_state == 2'b10)
        else $error("no full holdover after dead reference");
    a_mini_active: assert property (loop_state == 2'b01 [*2] |-> hold_active)
        else $error("hold not active in mini-holdover");
    a_locked_idle: assert property (loop_state == 2'b00 [*2] |-> !hold_active)
        else $error("hold active while locked");
    // main scenarios
    c_ctrl_write: cover property (reg_wr && reg_addr == 8'h40);
    c_mini: cover property (loop_state == 2'b01);
    c_full: cover property (loop_state == 2'b10);
endmodule : hmc_monitor
`default_nettype wire

// File: sim/test_holdover_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_holdover_mode_control;
    logic               mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0;
    logic               lk = 0, lost = 0, dead = 0, back = 0, hold_active;
    logic [7:0]         reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [1:0]         loop_state;
    logic [18:0]        hold_freq;
    hmc_pkg::hmc_freq_s fq = '{19'h0f00f, 19'h1a5c3, 19'h2b6d4};
    int                 num_errors = 0, n_compared = 0;
    // rows: control byte beside the frequency it should select
    logic [7:0]         r_ctl [6] = '{8'h80, 8'hc0, 8'h00, 8'hc8, 8'h90, 8'hd8};
    logic [18:0]        r_exp [6] = '{19'h2b6d4, 19'h1a5c3, 19'h0f00f, 19'h0f00f, 19'h1a5c3, 19'h2b6d4};
    always #5 mclk = ~mclk;
    hmc_holdover_ctrl dut_u (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_locked(lk), .ref_lost(lost),
        .ref_dead(dead), .ref_back(back), .loop_freqs(fq), .loop_state(loop_state),
        .hold_freq(hold_freq), .hold_active(hold_active));
    ////////////////////////////////////////////////////////////////
    // compare and bus tasks
    task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", {11'h0, e}, {11'h0, reg_rdata});
    endtask : rd
    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        rd(8'h40, 8'h88);
        wr(8'h41, 8'h5a);
        rd(8'h41, 8'h00);
        wr(8'h3e, 8'h12);
        rd(8'h3e, 8'h12);
        wr(8'h3f, 8'h34);
        rd(8'h3f, 8'h34);
        wr(8'h40, 8'h65);
        rd(8'h3e, 8'ha5);
        rd(8'h40, 8'h61);
        wr(8'h40, 8'h25);
        rd(8'h3f, 8'hd4);
        wr(8'h40, 8'h05);
        rd(8'h40, 8'h05);
        rd(8'h3e, 8'h12);
        $display("register tests done");
        @(posedge mclk);
        lk <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wr(8'h40, r_ctl[i]);
            rd(8'h40, r_ctl[i]);
            @(posedge mclk);
            lost <= 1'b1;
            @(posedge mclk);
            lost <= 1'b0;
            fq.instant <= 19'h70707;
            repeat (4) @(posedge mclk);
            #1 chk("hold_freq", r_exp[i], hold_freq);
            chk("hold_active", 19'h1, {18'h0, hold_active});
            @(posedge mclk);
            lk <= 1'b0;
            dead <= 1'b1;
            @(posedge mclk);
            dead <= 1'b0;
            repeat (3) @(posedge mclk);
            #1 chk("loop_state", 19'h2, {17'h0, loop_state});
            @(posedge mclk);
            lk <= 1'b1;
            fq.instant <= 19'h0f00f;
            repeat (4) @(posedge mclk);
            #1 chk("loop_state", 19'h0, {17'h0, loop_state});
            $display("row %0d done", i);
        end
        // reference returns during mini-holdover: loop goes back to locked
        @(posedge mclk);
        lost <= 1'b1;
        @(posedge mclk);
        lost <= 1'b0;
        back <= 1'b1;
        @(posedge mclk);
        back <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk("loop_state", 19'h0, {17'h0, loop_state});
        chk("hold_active", 19'h0, {18'h0, hold_active});
        $display("reference return test done");
        end_sim();
    end
    // watchdog
    initial begin
        #20us;
        num_errors++;
        end_sim();
    end
endmodule : test_holdover_mode_control
bind hmc_holdover_ctrl hmc_monitor mon_u (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ref_lost(ref_lost), .ref_dead(ref_dead), .loop_state(loop_state), .hold_freq(hold_freq),
    .hold_active(hold_active));
`default_nettype wire

// File: verilog/hmc_freq_select.sv
`timescale 1ns/1ps
`default_nettype none
module hmc_freq_select (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              srst,
    // selection
    input  wire logic [1:0]        src_sel,
    input  wire logic              capture,
    input  wire hmc_pkg::hmc_freq_s freqs,
    // result
    output logic [18:0]            freq_out
);

    logic [18:0] frozen_reg;

    // hold the instantaneous value caught at entry
    always_ff @(posedge mclk) begin
        if (srst) begin
            frozen_reg <= '0;
        end else if (capture) begin
            frozen_reg <= freqs.instant;
        end
    end

    // pick the frequency source
    always_comb begin
        case (src_sel)
            2'b00:   freq_out = frozen_reg;
            2'b01:   freq_out = freqs.fast_avg;
            2'b10:   freq_out = freqs.slow_avg;
            default: freq_out = frozen_reg;
        endcase
    end

endmodule : hmc_freq_select
`default_nettype wire

// File: verilog/hmc_holdover_ctrl.sv
// Summary of operation
// - read_average 0: manual frequency word reads back the written value
// - read_average 1: word reads fast or slow average per fast_averaging
// - mini-holdover runs as holdover, frequency from instant, fast or slow
// - mode 00: mini-holdover uses the full holdover method
// - mode 01: frequency frozen at instantaneous value on entry
// - mode 10: frequency taken from fast averager
// - control register read/write, resets to 8'h88
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module hmc_holdover_ctrl (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               srst,
    // register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata,
    // timing loop status
    input  wire logic               loop_locked,
    input  wire logic               ref_lost,
    input  wire logic               ref_dead,
    input  wire logic               ref_back,
    input  wire hmc_pkg::hmc_freq_s loop_freqs,
    // timing loop control
    output logic [1:0]              loop_state,
    output logic [18:0]             hold_freq,
    output logic                    hold_active
);

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]          ctrl_reg;
    logic [15:0]         man_lo_reg;
    hmc_pkg::hmc_state_e state_reg;
    hmc_pkg::hmc_state_e state_next;
    logic [1:0]          mini_src;
    logic [1:0]          full_src;
    logic [1:0]          sel;
    logic                enter_hold;
    logic [18:0]         sel_freq;
    logic [18:0]         manual_word;
    logic [18:0]         avg_word;
    logic [18:0]         rd_word;

    // control register
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_reg <= hmc_pkg::HOLD_CTRL_RESET;
        end else if (reg_wr && reg_addr == hmc_pkg::ADDR_HOLD_CTRL) begin
            ctrl_reg <= reg_wdata;
        end
    end

    // lower manual frequency bytes at 0x3e and 0x3f
    always_ff @(posedge mclk) begin
        if (srst) begin
            man_lo_reg <= hmc_pkg::HOLD_FREQ_LO_RESET;
        end else if (reg_wr && reg_addr == hmc_pkg::ADDR_HOLD_FREQ_LO) begin
            man_lo_reg[15:8] <= reg_wdata;
        end else if (reg_wr && reg_addr == hmc_pkg::ADDR_HOLD_FREQ_LO + 8'h01) begin
            man_lo_reg[7:0] <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readback

    assign manual_word = {ctrl_reg[hmc_pkg::FREQ_TOP_HI:0], man_lo_reg};
    assign avg_word    = ctrl_reg[hmc_pkg::BIT_FAST_AVG] ? loop_freqs.fast_avg
                                                         : loop_freqs.slow_avg;
    assign rd_word     = ctrl_reg[hmc_pkg::BIT_READ_AVG] ? avg_word
                                                         : manual_word;

    // read data stand one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                hmc_pkg::ADDR_HOLD_CTRL:
                    reg_rdata <= {ctrl_reg[7:3], rd_word[18:16]};
                hmc_pkg::ADDR_HOLD_FREQ_LO:
                    reg_rdata <= rd_word[15:8];
                hmc_pkg::ADDR_HOLD_FREQ_LO + 8'h01:
                    reg_rdata <= rd_word[7:0];
                default:
                    reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // loop state

    // locked loses reference: mini-holdover; dead input: full holdover
    always_comb begin
        case (state_reg)
            hmc_pkg::HMC_ST_LOCKED:
                state_next = ref_lost ? hmc_pkg::HMC_ST_MINI : hmc_pkg::HMC_ST_LOCKED;
            hmc_pkg::HMC_ST_MINI:
                state_next = ref_back ? hmc_pkg::HMC_ST_LOCKED
                           : ref_dead ? hmc_pkg::HMC_ST_FULL : hmc_pkg::HMC_ST_MINI;
            hmc_pkg::HMC_ST_FULL:
                state_next = loop_locked ? hmc_pkg::HMC_ST_LOCKED : hmc_pkg::HMC_ST_FULL;
            hmc_pkg::HMC_ST_FREE:
                state_next = loop_locked ? hmc_pkg::HMC_ST_LOCKED : hmc_pkg::HMC_ST_FREE;
            default:
                state_next = hmc_pkg::HMC_ST_FREE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= hmc_pkg::HMC_ST_FREE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source selection

    // full holdover method: averaged when auto_averaging set, else frozen
    assign full_src = ctrl_reg[hmc_pkg::BIT_AUTO_AVG]
                    ? (ctrl_reg[hmc_pkg::BIT_FAST_AVG] ? 2'b01 : 2'b10)
                    : 2'b00;

    // mini-holdover source
    always_comb begin
        case (hmc_pkg::hmc_mini_e'(ctrl_reg[hmc_pkg::MINI_MODE_HI:hmc_pkg::MINI_MODE_LO]))
            hmc_pkg::HMC_MINI_AS_FULL: mini_src = full_src;
            hmc_pkg::HMC_MINI_FREEZE:  mini_src = 2'b00;
            hmc_pkg::HMC_MINI_FAST:    mini_src = 2'b01;
            hmc_pkg::HMC_MINI_SLOW:    mini_src = 2'b10;
            default:                   mini_src = full_src;
        endcase
    end

    // mini-holdover uses the same machinery as holdover
    assign sel        = (state_reg == hmc_pkg::HMC_ST_MINI) ? mini_src : full_src;
    assign enter_hold = (state_reg == hmc_pkg::HMC_ST_LOCKED) && ref_lost;

    hmc_freq_select u_sel (
        .mclk     (mclk),
        .srst     (srst),
        .src_sel  (sel),
        .capture  (enter_hold),
        .freqs    (loop_freqs),
        .freq_out (sel_freq)
    );

    // registered loop outputs
    always_ff @(posedge mclk) begin
        if (srst) begin
            loop_state  <= 2'b11;
            hold_freq   <= '0;
            hold_active <= 1'b0;
        end else begin
            loop_state  <= state_reg;
            hold_freq   <= sel_freq;
            hold_active <= (state_reg == hmc_pkg::HMC_ST_MINI) ||
                           (state_reg == hmc_pkg::HMC_ST_FULL);
        end
    end

endmodule : hmc_holdover_ctrl
`default_nettype wire

// File: verilog/hmc_pkg.sv
package hmc_pkg;

    // register map
    localparam logic [7:0]  ADDR_HOLD_FREQ_LO   = 8'h3e;  // manual hold frequency [15:8]
    localparam logic [7:0]  ADDR_HOLD_CTRL      = 8'h40;  // hold_behaviour_control
    localparam logic [7:0]  HOLD_CTRL_RESET     = 8'h88;
    localparam logic [15:0] HOLD_FREQ_LO_RESET  = 16'h0000;

    // field positions in hold_behaviour_control
    localparam int BIT_AUTO_AVG   = 7;
    localparam int BIT_FAST_AVG   = 6;
    localparam int BIT_READ_AVG   = 5;
    localparam int MINI_MODE_HI   = 4;
    localparam int MINI_MODE_LO   = 3;
    localparam int FREQ_TOP_HI    = 2;

    // mini-holdover source selection
    typedef enum logic [1:0] {
        HMC_MINI_AS_FULL = 2'b00,
        HMC_MINI_FREEZE  = 2'b01,
        HMC_MINI_FAST    = 2'b10,
        HMC_MINI_SLOW    = 2'b11
    } hmc_mini_e;

    // loop state seen from the timing loop
    typedef enum logic [1:0] {
        HMC_ST_LOCKED = 2'b00,
        HMC_ST_MINI   = 2'b01,
        HMC_ST_FULL   = 2'b10,
        HMC_ST_FREE   = 2'b11
    } hmc_state_e;

    // frequency sources offered by the loop
    typedef struct packed {
        logic [18:0] instant;
        logic [18:0] fast_avg;
        logic [18:0] slow_avg;
    } hmc_freq_s;

endpackage : hmc_pkg
